// ==== design/timer_pkg.sv ====
// constants, register map and field layout of the dual 8-bit timer / event counter
//
// Function
// - timer mode counts each selected prescaler tick
// - timer match raises interrupt, clears, keeps counting
// - event mode counts count pin falling edges
// - event match raises interrupt, clears, waits edge
// - compare value has no shadow, acts at once
// - two counters cascade into one 16-bit counter
// - cascade uses lower clock select and pin
// - slowest tap follows divider select and speed mode
// - run bit clear stops and zeroes counter; cascade obeys upper run bit only
package timer_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL0 = 8'h00; // lower counter control
    localparam logic [7:0] OFF_CTRL1 = 8'h04; // upper counter control
    localparam logic [7:0] OFF_CMP0 = 8'h08; // lower compare_value_reg
    localparam logic [7:0] OFF_CMP1 = 8'h0c; // upper compare_value_reg
    localparam logic [7:0] OFF_COUNT = 8'h10; // live counts, read only
    localparam logic [7:0] OFF_STAT = 8'h14; // sticky match status, w1c
    localparam logic [7:0] OFF_MASK = 8'h18; // interrupt mask
    localparam logic [7:0] OFF_SYS = 8'h1c; // divider tap and speed mode
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CS_LSB = 0; // clock select, three bits
    localparam int RUN_BIT = 3; // run_control_bit
    localparam int CASC_BIT = 4; // ctrl1 only: 16-bit cascade
    localparam int OFV_BIT = 7; // output_ff_initial_value, stored only
    localparam int DVSEL_BIT = 0; // divider_tap_select
    localparam int SLOW_BIT = 1; // 1: slow_run_mode / slow_idle_mode
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CMP_RST = 8'hff;
    localparam logic [1:0] IRQ_RST = 2'h0;
    localparam logic [1:0] SYS_RST = 2'h0;
    // ------------------------------------------------------------
    // clock select codes, also the tap vector index
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CS_SLOWEST = 3'b000, // high_freq_clock/2^11 or low_freq_clock/2^3
        CS_FC128 = 3'b001,
        CS_FC32 = 3'b010,
        CS_FC8 = 3'b011,
        CS_FS = 3'b100,
        CS_FC2 = 3'b101,
        CS_FC = 3'b110,
        CS_PIN = 3'b111 // count_input_pin falling edge
    } clk_sel_t;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 250; // system clock rate
    localparam int FS_KHZ = 32; // low_freq_clock nominal rate, in kHz
    localparam int FS_DIV = CLK_MHZ * 1000 / FS_KHZ; // clocks per fs tick
    localparam int DIV_BITS = 11; // prescaler width, top tap 2^11
endpackage

// ==== design/tap_divider.sv ====
// free-running prescaler: one-cycle enables for every internal tap
`timescale 1ns/1ns
module tap_divider
    import timer_pkg::*;
#(
    parameter int FS_CYC = FS_DIV // clocks per low_freq_clock tick
) (
    input wire logic clk, // system clock
    input wire logic rstn, // async reset, active low
    output logic [7:0] tapEn // tick enables, indexed by clk_sel_t
);
    logic [DIV_BITS-1:0] divCnt; // high_freq_clock prescaler
    logic [15:0] fsCnt; // low_freq_clock generator
    logic [2:0] fs8Cnt; // fs/2^3 stage
    logic fsEn; // one-cycle fs tick

    // ------------------------------------------------------------
    // prescaler chains
    // ------------------------------------------------------------
    // fc chain never stops so taps stay phase-locked to each other
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            divCnt <= '0;
        end else begin
            divCnt <= divCnt + 11'd1;
        end
    end

    // fs is synthesised from the one clock by a divider
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fsCnt <= '0;
            fs8Cnt <= '0;
        end else if (fsEn) begin
            fsCnt <= '0;
            fs8Cnt <= fs8Cnt + 3'd1;
        end else begin
            fsCnt <= fsCnt + 16'd1;
        end
    end

    assign fsEn = (fsCnt == 16'(FS_CYC - 1));

    // ------------------------------------------------------------
    // tap enables
    // ------------------------------------------------------------
    assign tapEn[CS_SLOWEST] = &divCnt; // fc/2^11
    assign tapEn[CS_FC128] = &divCnt[6:0];
    assign tapEn[CS_FC32] = &divCnt[4:0];
    assign tapEn[CS_FC8] = &divCnt[2:0];
    assign tapEn[CS_FS] = fsEn;
    assign tapEn[CS_FC2] = divCnt[0];
    assign tapEn[CS_FC] = 1'b1;
    assign tapEn[CS_PIN] = fsEn & (&fs8Cnt); // fs/2^3 parked in spare slot
endmodule

// ==== design/timer_pair.sv ====
// two cascadable 8-bit timer / event counters behind an AHB-Lite slave
//
// The register addresses and register access over AHB-Lite were decided locally.
`timescale 1ns/1ns
module timer_pair
    import timer_pkg::*;
#(
    parameter int FS_CYC = FS_DIV // clocks per low_freq_clock tick
) (
    input wire logic clk, // system clock, 250 MHz
    input wire logic rstn, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // 1 write, 0 read
    input wire logic [2:0] hsize, // word only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // always ready
    output logic hresp, // always OKAY
    input wire logic [1:0] countInputPin, // count_input_pin per counter
    output logic [1:0] matchIrq, // match_irq pulses
    output logic irq // level interrupt
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] ctrl0_reg, ctrl1_reg; // control words
    logic [7:0] cmp0_reg, cmp1_reg; // compare_value_reg, no shadow
    logic [7:0] cnt0_reg, cnt1_reg; // up-counters
    logic [1:0] stat_reg, stat_next; // sticky match status
    logic [1:0] mask_reg, mask_next; // interrupt mask
    logic [1:0] sys_reg; // divider_tap_select, slow mode
    logic wrPend_reg; // write data phase pending
    logic [7:0] wrAddr_reg; // latched write offset
    logic [1:0] pinS1_reg, pinS2_reg, pinPrev_reg; // pin synchroniser
    logic [7:0] tapEn; // prescaler enables
    logic [1:0] fall; // synced falling edge
    logic src0, src1; // selected source ticks
    logic run0, run1, casc; // decoded control
    logic [7:0] inc0, inc1; // counts plus one
    logic [15:0] inc16; // cascaded count plus one
    logic m0, m1, m16; // match next tick
    logic [1:0] ev; // match events this cycle
    logic addrPh; // address phase accepted
    logic [1:0] w1c; // status bits cleared by write

    tap_divider #(
        .FS_CYC(FS_CYC)
    ) u_div (
        .clk(clk),
        .rstn(rstn),
        .tapEn(tapEn)
    );

    // ------------------------------------------------------------
    // source tick selection
    // ------------------------------------------------------------
    // fc-derived taps are dead in slow mode: the fast oscillator is off
    function automatic logic selTick(input logic [2:0] cs, input logic slow,
            input logic dv, input logic [7:0] taps, input logic edgeIn);
        logic t;
        t = 1'b0;
        unique case (clk_sel_t'(cs))
            CS_SLOWEST: t = (slow | dv) ? taps[CS_PIN] : taps[CS_SLOWEST];
            CS_FS: t = taps[CS_FS];
            CS_PIN: t = edgeIn;
            CS_FC128, CS_FC32, CS_FC8, CS_FC2, CS_FC: t = !slow & taps[cs];
        endcase
        return t;
    endfunction

    assign run0 = ctrl0_reg[RUN_BIT];
    assign run1 = ctrl1_reg[RUN_BIT];
    assign casc = ctrl1_reg[CASC_BIT];
    // cascade takes lower select and lower pin only
    assign src0 = selTick(ctrl0_reg[CS_LSB+:3], sys_reg[SLOW_BIT],
        sys_reg[DVSEL_BIT], tapEn, fall[0]);
    assign src1 = selTick(ctrl1_reg[CS_LSB+:3], sys_reg[SLOW_BIT],
        sys_reg[DVSEL_BIT], tapEn, fall[1]);

    // ------------------------------------------------------------
    // count pin synchroniser and edge detect
    // ------------------------------------------------------------
    // pulses shorter than a few clocks may be missed; the source keeps
    // each level long enough
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pinS1_reg <= 2'h3;
            pinS2_reg <= 2'h3;
            pinPrev_reg <= 2'h3;
        end else begin
            pinS1_reg <= countInputPin;
            pinS2_reg <= pinS1_reg;
            pinPrev_reg <= pinS2_reg;
        end
    end

    assign fall = pinPrev_reg & ~pinS2_reg;

    // ------------------------------------------------------------
    // match detection
    // ------------------------------------------------------------
    // compare reads the live register, so a rewrite acts at once
    assign inc0 = cnt0_reg + 8'h01;
    assign inc1 = cnt1_reg + 8'h01;
    assign inc16 = {cnt1_reg, cnt0_reg} + 16'h0001;
    assign m0 = (inc0 == cmp0_reg);
    assign m1 = (inc1 == cmp1_reg);
    assign m16 = (inc16 == {cmp1_reg, cmp0_reg});
    assign ev[0] = !casc & run0 & src0 & m0;
    assign ev[1] = casc ? (run1 & src0 & m16) : (run1 & src1 & m1);

    // ------------------------------------------------------------
    // lower counter
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt0_reg <= '0;
        end else if (casc) begin
            // 16-bit: upper run bit governs both halves
            if (!run1) begin
                cnt0_reg <= '0;
            end else if (src0) begin
                cnt0_reg <= m16 ? 8'h00 : inc16[7:0];
            end
        end else if (!run0) begin
            cnt0_reg <= '0;
        end else if (src0) begin
            cnt0_reg <= m0 ? 8'h00 : inc0;
        end
    end

    // ------------------------------------------------------------
    // upper counter
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt1_reg <= '0;
        end else if (!run1) begin
            cnt1_reg <= '0;
        end else if (casc) begin
            // carry from lower half drives the upper half
            if (src0) begin
                cnt1_reg <= m16 ? 8'h00 : inc16[15:8];
            end
        end else if (src1) begin
            cnt1_reg <= m1 ? 8'h00 : inc1;
        end
    end

    // ------------------------------------------------------------
    // match pulses, sticky status, interrupt
    // ------------------------------------------------------------
    // pulse leaves the flop on the same edge that zeroes the counter
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            matchIrq <= IRQ_RST;
        end else begin
            matchIrq <= ev;
        end
    end

    // a set in the clearing cycle survives the clear
    assign stat_next = (stat_reg & ~w1c) | ev;
    assign mask_next = (wrPend_reg && wrAddr_reg == OFF_MASK) ? hwdata[1:0] : mask_reg;
    assign w1c = (wrPend_reg && wrAddr_reg == OFF_STAT) ? hwdata[1:0] : 2'h0;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stat_reg <= IRQ_RST;
            mask_reg <= IRQ_RST;
            irq <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            irq <= |(stat_next & mask_next); // from next values, no extra lag
        end
    end

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    // zero wait states; only word transfers are meaningful
    assign addrPh = hsel & htrans[1] & hready;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wrPend_reg <= 1'b0;
            wrAddr_reg <= '0;
        end else begin
            wrPend_reg <= addrPh & hwrite;
            wrAddr_reg <= haddr[7:0];
        end
    end

    function automatic logic [31:0] regRead(input logic [7:0] a);
        logic [31:0] d;
        d = '0;
        if (a == OFF_CTRL0) d[7:0] = ctrl0_reg;
        else if (a == OFF_CTRL1) d[7:0] = ctrl1_reg;
        else if (a == OFF_CMP0) d[7:0] = cmp0_reg;
        else if (a == OFF_CMP1) d[7:0] = cmp1_reg;
        else if (a == OFF_COUNT) d[15:0] = {cnt1_reg, cnt0_reg};
        else if (a == OFF_STAT) d[1:0] = stat_reg;
        else if (a == OFF_MASK) d[1:0] = mask_reg;
        else if (a == OFF_SYS) d[1:0] = sys_reg;
        return d; // unmapped offsets read zero
    endfunction

    // read data is launched in the address phase, stands in data phase
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hrdata <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (addrPh && !hwrite) begin
                hrdata <= regRead(haddr[7:0]);
            end
        end
    end

    // control and config writes in the data phase
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl0_reg <= CTRL_RST;
            ctrl1_reg <= CTRL_RST;
            sys_reg <= SYS_RST;
        end else if (wrPend_reg) begin
            // initial-value bit is held but drives no output here
            if (wrAddr_reg == OFF_CTRL0) ctrl0_reg <= hwdata[7:0];
            if (wrAddr_reg == OFF_CTRL1) ctrl1_reg <= hwdata[7:0];
            if (wrAddr_reg == OFF_SYS) sys_reg <= hwdata[1:0];
        end
    end

    // compare registers: no shadow, range is software's duty
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cmp0_reg <= CMP_RST;
            cmp1_reg <= CMP_RST;
        end else if (wrPend_reg) begin
            if (wrAddr_reg == OFF_CMP0) cmp0_reg <= hwdata[7:0];
            if (wrAddr_reg == OFF_CMP1) cmp1_reg <= hwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    AST_STOP_CLEAR: assert property (!casc && !run0 |=> cnt0_reg == 8'h00)
        else $error("stopped lower counter not zero");
    AST_MATCH_ZERO: assert property (matchIrq[0] |-> cnt0_reg == 8'h00)
        else $error("match pulse without cleared counter");
    AST_MATCH_CAUSE: assert property (matchIrq[0] |-> $past(inc0) == $past(cmp0_reg))
        else $error("match pulse without compare equality");
    AST_TIMER_INC: assert property (!casc && run0 && src0 && !m0
            |=> cnt0_reg == $past(inc0))
        else $error("timer did not step on tick");
    AST_EDGE_ONLY: assert property (!casc && run0 && clk_sel_t'(ctrl0_reg[2:0]) == CS_PIN
            && !fall[0] |=> $stable(cnt0_reg))
        else $error("event counter moved without pin edge");
    AST_EVENT_WRAP: assert property (!casc && run0 && clk_sel_t'(ctrl0_reg[2:0]) == CS_PIN
            && fall[0] && m0 |=> cnt0_reg == 8'h00 && matchIrq[0])
        else $error("event match did not clear");
    AST_CMP_NOW: assert property (wrPend_reg && wrAddr_reg == OFF_CMP0
            |=> cmp0_reg == $past(hwdata[7:0]))
        else $error("compare write not immediate");
    AST_CASC_CARRY: assert property (casc && run1 && src0 && cnt0_reg == 8'hff && !m16
            |=> cnt1_reg == $past(inc1) && cnt0_reg == 8'h00)
        else $error("cascade carry lost");
    AST_CASC_SRC: assert property (casc && run1 && !src0
            |=> $stable({cnt1_reg, cnt0_reg}))
        else $error("cascade moved without lower source");
    AST_SLOW_TAP: assert property (sys_reg[SLOW_BIT] && ctrl0_reg[2:0] == 3'h0
            |-> src0 == tapEn[CS_PIN])
        else $error("slowest tap wrong in slow mode");

    // ------------------------------------------------------------
    // upper half, cascade, status, tap and bus checks
    // ------------------------------------------------------------
    // a stopped upper half must not keep a stale count for restart
    AST_STOP_CLEAR1: assert property (!run1 |=> cnt1_reg == 8'h00)
        else $error("stopped upper counter not zero");

    // in cascade the upper run bit also stops the lower half
    AST_CASC_STOP: assert property (casc && !run1 |=> cnt0_reg == 8'h00)
        else $error("stopped cascade lower half not zero");

    // upper pulse must leave with the cleared count, cascade or not
    AST_MATCH1_ZERO: assert property (matchIrq[1] |-> cnt1_reg == 8'h00)
        else $error("upper match pulse without cleared counter");

    // lower interrupt is silent while the halves work as one
    AST_CASC_QUIET: assert property (casc |=> !matchIrq[0])
        else $error("lower pulse during cascade");

    // 16-bit match clears both halves and pulses the upper request
    AST_CASC_MATCH: assert property (casc && run1 && src0 && m16
            |=> matchIrq[1] && cnt0_reg == 8'h00)
        else $error("cascade match not taken");

    // a match in the clearing cycle must still leave the bit set
    AST_STAT_SET: assert property (ev[0] |=> stat_reg[0])
        else $error("match did not set status");

    // fast mode with the divider tap select low uses the fc chain
    AST_FAST_SLOWEST: assert property (!sys_reg[SLOW_BIT] && !sys_reg[DVSEL_BIT]
            && ctrl0_reg[2:0] == 3'h0 |-> src0 == tapEn[CS_SLOWEST])
        else $error("slowest tap wrong in fast mode");

    // the fast oscillator is off in slow mode, so fc ticks are dead
    AST_SLOW_DEAD: assert property (sys_reg[SLOW_BIT] && ctrl0_reg[2:0] == 3'h6
            |-> !src0)
        else $error("fc tick seen in slow mode");

    // upper event counter moves only on its own pin edge
    AST_UPPER_EDGE: assert property (!casc && run1 && ctrl1_reg[2:0] == 3'h7
            && !fall[1] |=> $stable(cnt1_reg))
        else $error("upper event counter moved without pin edge");

    // level interrupt follows status and mask with no extra lag
    AST_IRQ_LEVEL: assert property (irq == |(stat_reg & mask_reg))
        else $error("interrupt level disagrees with status");

    // the slave never stalls and never errors
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("slave stalled or errored");

    COV_TIMER_MATCH: cover property (!casc && run0 ##1 matchIrq[0]);
    COV_EVENT_MATCH: cover property (ctrl0_reg[2:0] == 3'h7 && matchIrq[0]);
    COV_SLOW_MATCH: cover property (sys_reg[SLOW_BIT] && matchIrq[0]);
    COV_CASC_MATCH: cover property (casc ##1 matchIrq[1]);
    COV_IRQ: cover property (!irq ##1 irq);
endmodule

// ==== sim/pulse_source.sv ====
// partner model: external pulse source on the two count input pins
`timescale 1ns/1ns
module pulse_source (
    input wire logic clk, // system clock
    input wire logic start, // one-cycle burst request
    input wire logic [1:0] pinSel, // pins that pulse in this burst
    input wire logic [7:0] nPulses, // falling edges per burst
    input wire logic [7:0] halfLen, // cycles per level, kept >= 4
    output logic busy, // burst in progress
    output logic [1:0] pinOut // count pins, idle high like a pull-up
);
    logic [1:0] sel; // latched pin choice
    logic [7:0] num; // latched edge count
    logic [7:0] len; // latched level length
    initial begin
        pinOut = 2'h3;
        busy = 1'b0;
    end
    // ------------------------------------------------------------
    // burst generator
    // ------------------------------------------------------------
    // each low and high level lasts len cycles so the pin synchroniser
    // never misses an edge; fewer cycles would model an illegal source
    always begin
        @(posedge clk);
        if (start === 1'b1) begin
            sel = pinSel;
            num = nPulses;
            len = halfLen;
            busy <= 1'b1;
            repeat (num) begin
                pinOut <= ~sel;
                repeat (len) @(posedge clk);
                pinOut <= 2'h3;
                repeat (len) @(posedge clk);
            end
            busy <= 1'b0;
        end
    end
endmodule

// ==== sim/dual_8bit_timer_event_counter_tb.sv ====
// self-checking bench for the dual 8-bit timer / event counter
`timescale 1ns/1ns
`define CHK(got, exp) begin \
    samplesChecked++; \
    if ((got) !== (exp)) begin \
        badCount++; \
        $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); \
    end \
end
module dual_8bit_timer_event_counter_tb;
    import timer_pkg::*;
    typedef struct {logic [1:0] sys; logic [2:0] cs; logic [7:0] cmp; int per;} row_t;
    logic clk, rstn, hsel, hwrite, start; // bench-driven controls
    logic [31:0] haddr, hwdata, rd; // bus address, write data, read result
    logic [1:0] htrans, pinSel; // transfer type, burst pins
    logic [2:0] hsize; // always a word
    logic [7:0] nPulses, halfLen; // burst shape
    wire logic [31:0] hrdata; // read data
    wire logic hreadyout, hresp, irq, busy; // slave status, interrupt, partner busy
    wire logic [1:0] matchIrq, pinLine; // match pulses, count pins
    int badCount, samplesChecked, seen0, per; // counters
    logic [31:0] rstVal [9] = '{32'h0, 32'h0, 32'hff, 32'hff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    // expected period in clocks; FS_CYC is 8 so one fs tick is 8 clocks
    row_t rows [13] = '{'{2'h0, CS_FC, 8'h03, 3}, '{2'h0, CS_FC, 8'hff, 255},
        '{2'h0, CS_FC2, 8'h05, 10}, '{2'h0, CS_FC8, 8'h02, 16}, '{2'h0, CS_FC32, 8'h02, 64},
        '{2'h0, CS_FC128, 8'h02, 256}, '{2'h0, CS_SLOWEST, 8'h02, 4096},
        '{2'h1, CS_SLOWEST, 8'h02, 128}, '{2'h0, CS_FS, 8'h04, 32},
        '{2'h2, CS_SLOWEST, 8'h01, 64}, '{2'h2, CS_FS, 8'h04, 32},
        '{2'h2, CS_FC, 8'h03, 0}, '{2'h2, CS_FC8, 8'h03, 0}};
    timer_pair #(.FS_CYC(8)) u_timer_pair (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .countInputPin(pinLine),
        .matchIrq(matchIrq), .irq(irq));
    pulse_source u_pulse_source (.clk(clk), .start(start), .pinSel(pinSel), .nPulses(nPulses),
        .halfLen(halfLen), .busy(busy), .pinOut(pinLine));
    // ------------------------------------------------------------
    // clock, monitor, watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // counts lower match pulses, sampled mid-cycle where they are settled
    always @(negedge clk) begin
        if (matchIrq[0] === 1'b1) seen0++;
    end
    // the whole run needs about 10k cycles; 50k cycles means a hang
    initial begin
        #200000;
        badCount++;
        stopTest();
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic busXfer(input logic wr, input logic [7:0] off, input logic [31:0] val);
        @(posedge clk);
        haddr <= {24'h0, off};
        hwrite <= wr;
        htrans <= 2'b10;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hwdata <= val;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask
    task automatic busWrite(input logic [7:0] off, input logic [31:0] val);
        busXfer(1'b1, off, val);
    endtask
    task automatic busRead(input logic [7:0] off);
        busXfer(1'b0, off, 32'h0);
    endtask
    // per is the gap between two pulses, 0 if none came within lim
    task automatic measure(input int idx, input int lim, output int p);
        int n;
        p = 0;
        n = 0;
        @(negedge clk);
        while (matchIrq[idx] !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (n >= lim) return;
        @(negedge clk);
        `CHK(matchIrq[idx], 1'b0)
        p = 1;
        while (matchIrq[idx] !== 1'b1 && p < lim) begin
            @(negedge clk);
            p++;
        end
    endtask
    task automatic sendPulses(input logic [1:0] s, input logic [7:0] n);
        @(posedge clk);
        pinSel <= s;
        nPulses <= n;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        @(negedge clk);
        while (busy === 1'b1) @(negedge clk);
        repeat (8) @(negedge clk);
    endtask
    task automatic stopTest();
        if (badCount == 0 && samplesChecked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {rstn, hsel, hwrite, start} = 4'h0;
        {haddr, hwdata, htrans, pinSel, nPulses} = '0;
        hsize = 3'b010;
        halfLen = 8'h04;
        repeat (16) @(posedge clk);
        `CHK({hreadyout, hresp, matchIrq, irq}, 5'h10)
        rstn <= 1'b1;
        hsel <= 1'b1;
        // reset values, unmapped offset 0x20 included
        for (int i = 0; i < 9; i++) begin
            busRead(8'(4 * i));
            `CHK(rd, rstVal[i])
        end
        // every internal clock source in fast mode; slowest, fs, fc and fc/8 in slow mode
        foreach (rows[i]) begin
            busWrite(OFF_SYS, {30'h0, rows[i].sys});
            busWrite(OFF_CMP0, {24'h0, rows[i].cmp});
            busWrite(OFF_CTRL0, {28'h0, 1'b1, rows[i].cs});
            measure(0, 3 * rows[i].per + 64, per);
            `CHK(per, rows[i].per)
            busWrite(OFF_CTRL0, 32'h0);
            busRead(OFF_COUNT);
            `CHK(rd, 32'h0)
        end
        // sticky status, mask and level interrupt; unmapped write dropped
        busWrite(OFF_SYS, 32'h0);
        busRead(OFF_STAT);
        `CHK(rd, 32'h1)
        `CHK(irq, 1'b0)
        busWrite(OFF_MASK, 32'h1);
        repeat (2) @(negedge clk);
        `CHK(irq, 1'b1)
        busWrite(OFF_STAT, 32'h1);
        repeat (2) @(negedge clk);
        `CHK(irq, 1'b0)
        busWrite(8'h20, 32'hff);
        busRead(8'h20);
        `CHK(rd, 32'h0)
        // event counting, then a compare rewrite that must act at once
        busWrite(OFF_CMP0, 32'h3);
        busWrite(OFF_CTRL0, {28'h0, 1'b1, CS_PIN});
        seen0 = 0;
        repeat (20) @(negedge clk);
        busRead(OFF_COUNT);
        `CHK(rd, 32'h0)
        sendPulses(2'b01, 8'd7);
        `CHK(seen0, 2)
        busRead(OFF_COUNT);
        `CHK(rd, 32'h1)
        busWrite(OFF_CMP0, 32'h2);
        sendPulses(2'b01, 8'd1);
        `CHK(seen0, 3)
        busWrite(OFF_CTRL0, 32'h0);
        // cascade: compare 0x0104 from the lower clock select, pin1 ignored
        busWrite(OFF_CMP0, 32'h04);
        busWrite(OFF_CMP1, 32'h01);
        busWrite(OFF_CTRL0, {29'h0, CS_FC});
        busWrite(OFF_CTRL1, 32'h18);
        seen0 = 0;
        fork
            sendPulses(2'b10, 8'd20);
            measure(1, 900, per);
        join
        `CHK(per, 260)
        `CHK(seen0, 0)
        busWrite(OFF_CTRL1, 32'h0);
        stopTest();
    end
endmodule
